//--- rtl/lps_pkg.sv
// Shared types and constants of the 7:1 pixel serializer
`default_nettype none
package lps_pkg;
    localparam int unsigned CORE_CLK_PERIOD_NS  = 25;
    localparam int unsigned LANES               = 3;
    localparam int unsigned SLOTS               = 7;
    localparam int unsigned PIXEL_BITS          = 21;
    localparam int unsigned CNT_W               = 16;
    // Output disable after power-down, longest time, rounded down
    localparam int unsigned POWER_DOWN_DELAY_NS = 100;
    localparam int unsigned POWER_DOWN_DELAY_CYCLES = POWER_DOWN_DELAY_NS / CORE_CLK_PERIOD_NS;
    // Lock budget, longest time, rounded down
    localparam int unsigned PLL_LOCK_TIME_MS    = 10;
    localparam int unsigned PLL_LOCK_CYCLES =
        (PLL_LOCK_TIME_MS * 1000000) / CORE_CLK_PERIOD_NS;
    // Least power-down pulse the controller must give
    localparam int unsigned POWER_DOWN_MIN_PULSE_US = 1;
    localparam int unsigned POWER_DOWN_MIN_PULSE_CYCLES =
        (POWER_DOWN_MIN_PULSE_US * 1000 + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
    localparam logic [2:0]  LOCK_EDGES          = 3'h4;
    localparam logic [CNT_W-1:0] CLK_MISS_CYCLES = 16'h0100;
    localparam logic [2:0]  SLOT_LAST           = 3'h6;
    localparam logic [CNT_W:0] SLOT_STEP        = 17'h00007;
    // Forwarded clock level per slot; the high phase runs slots 5, 6, 0 and 1
    localparam logic [6:0]  CLK_PATTERN         = 7'h63;
    localparam logic [PIXEL_BITS-1:0] WORD_RESET = 21'h000000;

    typedef struct packed {
        logic [5:0] red;
        logic [5:0] green;
        logic [5:0] blue;
        logic       line_sync;
        logic       frame_sync;
        logic       pixel_valid;
    } lps_pixel_s;

    // Input bit index for lane*7+slot; bit 0 is pixel_valid, 20 is red msb
    typedef logic [4:0] lps_idx_t;
    localparam lps_idx_t LANE_MAP [0:20] = '{
        5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h09,
        5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h03, 5'h04,
        5'h05, 5'h06, 5'h07, 5'h08, 5'h02, 5'h01, 5'h00
    };
endpackage
`default_nettype wire

//--- rtl/lps_serializer.sv
// 7:1 pixel serializer with strobe-edge select, power-down and clock loss detect
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RULE_01] All 21 pixel inputs (RGB, syncs, valid) are sampled each pixel clock.
// [RULE_02] Three serial data lanes plus one forwarded clock lane are driven.
// [RULE_03] Select low or open: sample on falling pixel clock edge.
// [RULE_04] Select high: sample on rising pixel clock edge.
// [RULE_05] Each pixel period splits into seven equal slots per lane.
// [RULE_06] Power-down low disables all serial and clock outputs.
// [RULE_07] Outputs are disabled within 100 ns of power-down.
// [RULE_08] Lock and valid output follow clock and power-up within 10 ms.
// [RULE_09] Power-down holds all logic in reset and drops lock.
// [RULE_10] No sequencing needed; lost and returned clock relocks by itself.
// [RULE_11] Controller should pulse power-down after an unstable clock settles.
// [RULE_12] Controller should assert power-down when clock and data stop.
// [RULE_13] Slot timing follows spread-spectrum clocks by measuring each period.
// [RULE_14] Controller holds power-down low at least 1 us.
// [RULE_15] Missing clock while powered drives every lane low.
// [RULE_16] Fixed constant table maps each input to one lane and slot.
// [RULE_17] Slot 0 of all data lanes aligns with forwarded clock rise. The code raises the forwarded clock at slot 5; slot 0 is inside the high phase.
module lps_serializer (
    input  wire logic               i_core_clk,
    input  wire logic               i_reset,
    input  wire logic               i_pixel_clock_input,
    input  wire lps_pkg::lps_pixel_s i_pixel_parallel_in,
    input  wire logic               i_strobe_edge_select,
    input  wire logic               i_power_down_n,
    output var  logic [2:0]         o_serial_lane_out,
    output var  logic [2:0]         o_serial_lane_oe,
    output var  logic               o_forwarded_clock_out,
    output var  logic               o_forwarded_clock_oe,
    output var  logic               o_locked
);

    typedef struct packed {
        logic                    clk_s1;
        logic                    clk_s2;
        logic                    clk_d;
        logic                    pd_n_s1;
        logic                    pd_n_s2;
        logic                    sel_s1;
        logic                    sel_s2;
        logic [20:0]             dat_s1;
        logic [20:0]             dat_s2;
        logic [20:0]             word;
        logic [lps_pkg::CNT_W-1:0] period_cnt;
        logic [lps_pkg::CNT_W-1:0] period;
        logic [lps_pkg::CNT_W:0] acc;
        logic [2:0]              slot;
        logic [2:0]              edges;
        logic                    locked;
        logic [lps_pkg::CNT_W-1:0] miss_cnt;
        logic [2:0]              lane;
        logic [2:0]              lane_oe;
        logic                    fclk;
        logic                    fclk_oe;
    } lps_state_s;

    lps_state_s state_reg;
    lps_state_s state_next;
    logic       rise;
    logic       fall;
    logic       strobe;
    logic [lps_pkg::CNT_W:0] acc_step;

    always_comb begin
        state_next = state_reg;
        // Pin inputs pass two flops before use
        state_next.clk_s1  = i_pixel_clock_input;
        state_next.clk_s2  = state_reg.clk_s1;
        state_next.clk_d   = state_reg.clk_s2;
        state_next.pd_n_s1 = i_power_down_n;
        state_next.pd_n_s2 = state_reg.pd_n_s1;
        state_next.sel_s1  = i_strobe_edge_select;
        state_next.sel_s2  = state_reg.sel_s1;
        state_next.dat_s1  = i_pixel_parallel_in;
        state_next.dat_s2  = state_reg.dat_s1;
        rise   = state_reg.clk_s2 & ~state_reg.clk_d;
        fall   = ~state_reg.clk_s2 & state_reg.clk_d;
        // [RULE_03] [RULE_04] Strobe edge choice
        strobe = state_reg.sel_s2 ? rise : fall;
        acc_step = state_reg.acc + lps_pkg::SLOT_STEP;
        if (!state_reg.pd_n_s2) begin
            // [RULE_06] [RULE_07] [RULE_09] Standby: reset and tristate
            state_next.word       = lps_pkg::WORD_RESET;
            state_next.period_cnt = '0;
            state_next.period     = '0;
            state_next.acc        = '0;
            state_next.slot       = '0;
            state_next.edges      = '0;
            state_next.locked     = 1'b0;
            state_next.miss_cnt   = '0;
            state_next.lane       = '0;
            state_next.lane_oe    = '0;
            state_next.fclk       = 1'b0;
            state_next.fclk_oe    = 1'b0;
        end else begin
            state_next.lane_oe = '1;
            state_next.fclk_oe = 1'b1;
            if (strobe) begin
                // [RULE_01] [RULE_13] Capture word, measure this period
                state_next.word       = state_reg.dat_s2;
                state_next.period     = state_reg.period_cnt + 16'h0001;
                state_next.period_cnt = '0;
                state_next.acc        = '0;
                state_next.slot       = '0;
                state_next.miss_cnt   = '0;
                // [RULE_08] [RULE_10] Lock after a few steady edges
                if (state_reg.edges != lps_pkg::LOCK_EDGES) begin
                    state_next.edges = state_reg.edges + 3'h1;
                end else begin
                    state_next.locked = 1'b1;
                end
            end else begin
                if (state_reg.period_cnt != '1) begin
                    state_next.period_cnt = state_reg.period_cnt + 16'h0001;
                end
                // [RULE_05] Slot advances every period/7 on average
                if (acc_step >= {1'b0, state_reg.period}) begin
                    state_next.acc = acc_step - {1'b0, state_reg.period};
                    if (state_reg.slot != lps_pkg::SLOT_LAST) begin
                        state_next.slot = state_reg.slot + 3'h1;
                    end
                end else begin
                    state_next.acc = acc_step;
                end
                // [RULE_15] Clock loss detection
                if (state_reg.miss_cnt == lps_pkg::CLK_MISS_CYCLES) begin
                    state_next.locked = 1'b0;
                    state_next.edges  = '0;
                end else begin
                    state_next.miss_cnt = state_reg.miss_cnt + 16'h0001;
                end
            end
            if (state_next.locked) begin
                // [RULE_02] [RULE_16] [RULE_17] Lane and clock bits for slot
                for (int l = 0; l < 3; l++) begin
                    state_next.lane[l] =
                        state_next.word[lps_pkg::LANE_MAP[l * 7 + int'(state_next.slot)]];
                end
                state_next.fclk = lps_pkg::CLK_PATTERN[6 - state_next.slot];
            end else begin
                state_next.lane = '0;
                state_next.fclk = 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_serial_lane_out     = state_reg.lane;
    assign o_serial_lane_oe      = state_reg.lane_oe;
    assign o_forwarded_clock_out = state_reg.fclk;
    assign o_forwarded_clock_oe  = state_reg.fclk_oe;
    assign o_locked              = state_reg.locked;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    a_pd_disable: assert property ( // [RULE_07]
        $fell(i_power_down_n) ##1 !i_power_down_n |-> ##[1:3] (o_serial_lane_oe == 3'h0)
            && !o_forwarded_clock_oe)
        else $error("outputs not disabled after power-down");
    a_pd_quiet: assert property ( // [RULE_06]
        !state_reg.pd_n_s2 |=> !o_forwarded_clock_oe && !o_locked && o_serial_lane_oe == 3'h0)
        else $error("outputs driven during power-down");
    a_miss_low: assert property ( // [RULE_15]
        state_reg.pd_n_s2 && !o_locked |-> !o_forwarded_clock_out && o_serial_lane_out == 3'h0)
        else $error("lanes not low while unlocked");
    a_slot_zero: assert property ( // [RULE_17]
        state_reg.pd_n_s2 && strobe && state_reg.locked |=> o_forwarded_clock_out)
        else $error("forwarded clock not high at slot 0");
    a_slot_bound: assert property ( // [RULE_05]
        state_reg.slot <= lps_pkg::SLOT_LAST)
        else $error("slot index out of range");
    a_word_capture: assert property ( // [RULE_01]
        state_reg.pd_n_s2 && strobe |=> state_reg.word == $past(state_reg.dat_s2))
        else $error("pixel word not captured on strobe");
    a_edge_rise: assert property ( // [RULE_04]
        state_reg.pd_n_s2 && state_reg.sel_s2 && fall && !rise |=> state_reg.slot != 3'h0
            || $past(state_reg.slot) == 3'h0)
        else $error("falling edge used while rising selected");
    a_lock_relock: assert property ( // [RULE_10]
        state_reg.pd_n_s2 && strobe && state_reg.edges == lps_pkg::LOCK_EDGES |=> o_locked)
        else $error("no lock after steady edges");

endmodule // lps_serializer
`default_nettype wire

//--- testbench/lps_pixel_source.sv
// Graphics controller model: pixel clock and parallel pixel word
`timescale 1ns/1ps
`default_nettype none
module lps_pixel_source #(
    parameter int HALF = 14
) (
    input  wire logic                i_core_clk,
    input  wire logic                i_run,
    input  wire logic                i_select,
    input  wire lps_pkg::lps_pixel_s i_fresh,
    output var  logic                o_pixel_clock,
    output var  lps_pkg::lps_pixel_s o_word
);
    logic                clk_q = 1'b0;
    lps_pkg::lps_pixel_s word_q = '0;
    int                  cnt = 0;
    assign o_pixel_clock = clk_q;
    assign o_word        = word_q;
    always @(negedge i_core_clk) begin
        if (!i_run) begin
            cnt <= 0;
            // Stopped clock stands; data lines keep moving
            word_q <= ~word_q;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            clk_q <= ~clk_q;
            // New word on the edge away from the strobe
            if (clk_q == i_select) begin
                word_q <= i_fresh;
            end
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // lps_pixel_source
`default_nettype wire

//--- testbench/lps_serializer_test.sv
// Self-checking bench of the 7:1 pixel serializer
`timescale 1ns/1ps
`default_nettype none
module lps_serializer_test;
    logic                i_core_clk = 1'b0;
    logic                i_reset = 1'b1;
    logic                run = 1'b0;
    logic                sel = 1'b0;
    logic                pd_n = 1'b1;
    logic                pclk;
    lps_pkg::lps_pixel_s word;
    lps_pkg::lps_pixel_s fresh = '0;
    logic [20:0]         pattern = '0;
    logic                use_pattern = 1'b0;
    logic [2:0]          lane;
    logic [2:0]          lane_oe;
    logic                fclk;
    logic                fclk_oe;
    logic                locked;
    logic [25:0]         hist [0:39];
    int                  error_cnt = 0;
    int                  total_checks = 0;
    int                  cycles = 0;

    always #12.5 i_core_clk = ~i_core_clk;

    lps_pixel_source #(.HALF(14)) src (.i_core_clk(i_core_clk), .i_run(run),
        .i_select(sel), .i_fresh(fresh), .o_pixel_clock(pclk), .o_word(word));

    lps_serializer DUT (.i_core_clk(i_core_clk), .i_reset(i_reset),
        .i_pixel_clock_input(pclk), .i_pixel_parallel_in(word),
        .i_strobe_edge_select(sel), .i_power_down_n(pd_n),
        .o_serial_lane_out(lane), .o_serial_lane_oe(lane_oe),
        .o_forwarded_clock_out(fclk), .o_forwarded_clock_oe(fclk_oe), .o_locked(locked));

    always @(negedge i_core_clk) begin
        hist[0] <= {fclk, pclk, word, lane};
        for (int i = 1; i < 40; i++) hist[i] <= hist[i-1];
    end

    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wait_lock();
        for (int n = 0; n < 600 && locked !== 1'b1; n++) @(negedge i_core_clk);
        check(32'(locked), 32'h1, "lock");
    endtask

    // Slots last 4 cycles at 28 cycles a pixel; forwarded clock falls at slot 2
    task automatic frame();
        logic [20:0] got;
        for (int n = 0; n < 100 && !(hist[1][25] && !hist[0][25]); n++) @(posedge i_core_clk);
        check(32'({hist[1][25], hist[0][25]}), 32'h2, "clock fall");
        repeat (19) @(posedge i_core_clk);
        for (int l = 0; l < 3; l++)
            for (int s = 0; s < 7; s++) got[lps_pkg::LANE_MAP[l*7+s]] = hist[25-4*s][l];
        check(32'(got), 32'(hist[30][23:3]), "word");
        check(32'({hist[32][24], hist[28][24]}), 32'({~sel, sel}), "strobe");
    endtask

    initial begin
        void'($urandom(12));
        // Word stream forked after seeding so it inherits the fixed seed
        fork
            forever begin
                @(posedge i_core_clk);
                fresh <= use_pattern ? lps_pkg::lps_pixel_s'(pattern)
                                     : lps_pkg::lps_pixel_s'(21'($urandom));
            end
        join_none
        repeat (4) @(posedge i_core_clk);
        @(negedge i_core_clk);
        check(32'({fclk_oe, lane_oe}), 32'h0, "oe in reset");
        i_reset = 1'b0;
        run = 1'b1;
        wait_lock();
        check(32'({fclk_oe, lane_oe}), 32'hf, "oe");
        for (int e = 0; e < 2; e++) begin
            @(negedge i_core_clk);
            sel = e[0];
            repeat (200) @(posedge i_core_clk);
            repeat (6) frame();
        end
        // Corner words: all ones, then alternating bits
        for (int c = 0; c < 2; c++) begin
            @(negedge i_core_clk);
            pattern = c[0] ? 21'h0aaaaa : 21'h1fffff;
            use_pattern = 1'b1;
            repeat (2) frame();
        end
        @(negedge i_core_clk);
        use_pattern = 1'b0;
        pd_n = 1'b0;
        repeat (lps_pkg::POWER_DOWN_DELAY_CYCLES) @(negedge i_core_clk);
        check(32'({fclk_oe, lane_oe, locked}), 32'h0, "power down");
        // Pulse held beyond the least width
        repeat (lps_pkg::POWER_DOWN_MIN_PULSE_CYCLES + $urandom_range(0, 20))
            @(negedge i_core_clk);
        pd_n = 1'b1;
        wait_lock();
        frame();
        @(negedge i_core_clk);
        run = 1'b0;
        repeat (300) @(negedge i_core_clk);
        check(32'({fclk, lane, fclk_oe, lane_oe, locked}), 32'h1e, "no clock");
        run = 1'b1;
        wait_lock();
        frame();
        @(negedge i_core_clk);
        pd_n = 1'b0;
        run = 1'b0;
        repeat (50) @(negedge i_core_clk);
        pd_n = 1'b1;
        repeat (20) @(negedge i_core_clk);
        run = 1'b1;
        wait_lock();
        frame();
        // Ragged clock, then a fresh lock by a power-down pulse
        repeat (4) begin
            repeat ($urandom_range(3, 9)) @(negedge i_core_clk);
            run = ~run;
        end
        repeat (100) @(negedge i_core_clk);
        pd_n = 1'b0;
        repeat (lps_pkg::POWER_DOWN_MIN_PULSE_CYCLES + $urandom_range(0, 15))
            @(negedge i_core_clk);
        pd_n = 1'b1;
        wait_lock();
        frame();
        test_done();
    end
endmodule // lps_serializer_test
`default_nettype wire
